// [cebt_core.sv]
// CAN error state tracking, bit timing generator and their registers.
// Assumes a protocol engine that reports fault events as one-cycle pulses
// and an AXI4-Lite master on the same clock.
`default_nettype none
module cebt_core
    import cebt_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic I_INIT_MODE,
    input wire logic I_BUS_OFF_RECOVER,
    input wire cebt_event_s I_EVENT,
    input wire logic I_RX_EDGE,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic O_TQ_TICK,
    output logic O_SAMPLE,
    output logic O_LOOPBACK,
    output logic O_SILENT,
    output logic O_BUS_OFF,
    output logic O_PASSIVE,
    output logic O_IRQ
);
    logic [8:0] tec;
    logic [7:0] rec;
    logic warning_flag;
    logic passive_flag;
    logic bus_off_flag;
    logic [2:0] last_error_code;
    cebt_timing_s timing;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held;
    logic w_held;
    logic wr_go;
    logic [31:0] wr_mask;
    logic [9:0] next_tec;
    logic [8:0] next_rec;
    logic [7:0] next_rec_final;
    logic next_bus_off;
    logic next_warn;
    logic next_passive;
    logic [3:0] irq_set;
    logic [31:0] error_state_reg;
    logic [31:0] bit_timing_reg;

    assign wr_go = aw_held && w_held && !S_AXI_BVALID;
    assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                      {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign error_state_reg = {rec, tec[7:0], 9'h000, last_error_code,
                              1'b0, bus_off_flag, passive_flag,
                              warning_flag};
    assign bit_timing_reg = timing & 32'hc37f03ff;

    // Fault confinement arithmetic, one event of each direction per cycle.
    always_comb begin
        next_tec = {1'b0, tec};
        if (I_BUS_OFF_RECOVER) begin
            next_tec = 10'h000;
        end else if (!bus_off_flag) begin
            if (I_EVENT.tx_error) begin
                next_tec = next_tec + LARGE_STEP;
            end else if (I_EVENT.tx_ok && tec != 9'h000) begin
                next_tec = next_tec - SMALL_STEP;
            end
        end
        next_bus_off = !I_BUS_OFF_RECOVER &&
                       (bus_off_flag || next_tec > BUS_OFF_LIMIT);
        if (next_tec > BUS_OFF_LIMIT) begin
            next_tec = {1'b0, tec};
        end
        next_rec = {1'b0, rec};
        if (I_BUS_OFF_RECOVER) begin
            next_rec = 9'h000;
        end else if (!bus_off_flag) begin
            if (I_EVENT.rx_error) begin
                next_rec = next_rec + (I_EVENT.rx_error_large ?
                    LARGE_STEP[8:0] : SMALL_STEP[8:0]);
            end else if (I_EVENT.rx_ok && rec != 8'h00) begin
                next_rec = next_rec - SMALL_STEP[8:0];
            end
        end
        if (next_rec > REC_CEILING) begin
            next_rec_final = REC_RELOAD;
        end else begin
            next_rec_final = next_rec[7:0];
        end
        next_warn = next_tec >= WARN_LIMIT ||
                    {2'b00, next_rec_final} >= WARN_LIMIT;
        next_passive = next_tec >= PASSIVE_LIMIT ||
                       {2'b00, next_rec_final} >= PASSIVE_LIMIT;
    end

    // The flags are stored with the counters so they never lag them.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            tec <= ERROR_STATE_RST[TEC_POS +: 9];
            rec <= ERROR_STATE_RST[REC_POS +: 8];
            warning_flag <= ERROR_STATE_RST[WARN_POS];
            passive_flag <= ERROR_STATE_RST[PASSIVE_POS];
            bus_off_flag <= ERROR_STATE_RST[BUS_OFF_POS];
        end else begin
            tec <= next_tec[8:0];
            rec <= next_rec_final;
            warning_flag <= next_warn;
            passive_flag <= next_passive;
            bus_off_flag <= next_bus_off;
        end
    end

    // Hardware recording wins over a software write in the same cycle.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            last_error_code <= ERROR_STATE_RST[LEC_POS +: 3];
        end else if (I_EVENT.code_valid) begin
            last_error_code <= I_EVENT.code;
        end else if (wr_go && aw_held && aw_addr == ERROR_STATE_OFS &&
                     w_strb[0]) begin
            last_error_code <= w_data[LEC_POS +: 3];
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            timing <= BIT_TIMING_RST;
        end else if (wr_go && aw_addr == BIT_TIMING_OFS && I_INIT_MODE) begin
            timing <= (timing & ~wr_mask) | (w_data & wr_mask);
        end
    end

    assign irq_set[IRQ_WARN_POS] = next_warn && !warning_flag;
    assign irq_set[IRQ_PASSIVE_POS] = next_passive && !passive_flag;
    assign irq_set[IRQ_BUS_OFF_POS] = next_bus_off && !bus_off_flag;
    assign irq_set[IRQ_LEC_POS] = I_EVENT.code_valid;

    // Sticky status, cleared by writing one; a new event wins the clear.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            irq_status <= IRQ_RST;
            irq_mask <= IRQ_RST;
            O_IRQ <= 1'b0;
        end else begin
            if (wr_go && aw_addr == IRQ_STATUS_OFS && w_strb[0]) begin
                irq_status <= (irq_status & ~w_data[3:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
            if (wr_go && aw_addr == IRQ_MASK_OFS && w_strb[0]) begin
                irq_mask <= w_data[3:0];
            end
            O_IRQ <= |(irq_status & irq_mask);
        end
    end

    // Write channel: address and data are taken in either order.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                case (aw_addr)
                    ERROR_STATE_OFS, BIT_TIMING_OFS, IRQ_STATUS_OFS,
                    IRQ_MASK_OFS: S_AXI_BRESP <= RESP_OKAY;
                    default: S_AXI_BRESP <= RESP_SLVERR;
                endcase
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Readies come from flops so that no path runs from a bus input to a
    // bus output; they track the held flags and the pending response.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
        end else if (wr_go) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= RESP_OKAY;
            case (S_AXI_ARADDR)
                ERROR_STATE_OFS: S_AXI_RDATA <= error_state_reg;
                BIT_TIMING_OFS: S_AXI_RDATA <= bit_timing_reg;
                IRQ_STATUS_OFS: S_AXI_RDATA <= {28'h0000000, irq_status};
                IRQ_MASK_OFS: S_AXI_RDATA <= {28'h0000000, irq_mask};
                default: begin
                    S_AXI_RDATA <= 32'h00000000;
                    S_AXI_RRESP <= RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            S_AXI_ARREADY <= 1'b1;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // Bit timing: quantum divider, then sync, segment one and segment two.
    logic [9:0] presc_cnt;
    logic tq_tick;
    cebt_phase_e phase;
    logic [4:0] seg_cnt;
    logic [2:0] extend;
    logic [2:0] shrink;
    logic [4:0] seg1_len;
    logic [4:0] seg2_len;
    logic [2:0] jump_len;
    logic resynced;

    assign tq_tick = presc_cnt == timing.quantum_prescaler;
    assign seg1_len = {1'b0, timing.segment_one_length} + 5'h01;
    assign seg2_len = {2'b00, timing.segment_two_length} + 5'h01;
    assign jump_len = {1'b0, timing.resync_jump_width} + 3'h1;

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            presc_cnt <= 10'h000;
        end else if (tq_tick || I_INIT_MODE) begin
            presc_cnt <= 10'h000;
        end else begin
            presc_cnt <= presc_cnt + 10'h001;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            phase <= PH_SYNC;
            seg_cnt <= 5'h00;
            extend <= 3'h0;
            shrink <= 3'h0;
            resynced <= 1'b0;
            O_SAMPLE <= 1'b0;
            O_TQ_TICK <= 1'b0;
        end else if (I_INIT_MODE) begin
            phase <= PH_SYNC;
            seg_cnt <= 5'h00;
            extend <= 3'h0;
            shrink <= 3'h0;
            resynced <= 1'b0;
            O_SAMPLE <= 1'b0;
            O_TQ_TICK <= 1'b0;
        end else begin
            O_TQ_TICK <= tq_tick;
            O_SAMPLE <= 1'b0;
            // One resynchronisation per bit, bounded by the jump width.
            if (I_RX_EDGE && !resynced && phase == PH_SEG1) begin
                resynced <= 1'b1;
                extend <= (seg_cnt + 5'h01 < {2'b00, jump_len}) ?
                    3'(seg_cnt + 5'h01) : jump_len;
            end
            if (I_RX_EDGE && !resynced && phase == PH_SEG2) begin
                resynced <= 1'b1;
                shrink <= (seg2_len - seg_cnt - 5'h01 < {2'b00, jump_len}) ?
                    3'(seg2_len - seg_cnt - 5'h01) : jump_len;
            end
            if (tq_tick) begin
                case (phase)
                    PH_SYNC: begin
                        phase <= PH_SEG1;
                        seg_cnt <= 5'h00;
                        extend <= 3'h0;
                        shrink <= 3'h0;
                        resynced <= 1'b0;
                    end
                    PH_SEG1: begin
                        if (seg_cnt + 5'h01 >= seg1_len + 5'(extend)) begin
                            phase <= PH_SEG2;
                            seg_cnt <= 5'h00;
                            O_SAMPLE <= 1'b1;
                        end else begin
                            seg_cnt <= seg_cnt + 5'h01;
                        end
                    end
                    PH_SEG2: begin
                        if (seg_cnt + 5'h01 + 5'(shrink) >= seg2_len) begin
                            phase <= PH_SYNC;
                            seg_cnt <= 5'h00;
                        end else begin
                            seg_cnt <= seg_cnt + 5'h01;
                        end
                    end
                    default: phase <= PH_SYNC;
                endcase
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_LOOPBACK <= 1'b0;
            O_SILENT <= 1'b0;
            O_BUS_OFF <= 1'b0;
            O_PASSIVE <= 1'b0;
        end else begin
            O_LOOPBACK <= timing.loopback_enable;
            O_SILENT <= timing.silent_enable;
            O_BUS_OFF <= bus_off_flag;
            O_PASSIVE <= passive_flag;
        end
    end

    a_warn_level: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        warning_flag == (tec >= 9'h060 || rec >= 8'h60))
        else $error("warning flag disagrees with counters");
    a_passive_level: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        passive_flag == (tec >= 9'h07f || rec >= 8'h7f))
        else $error("passive flag disagrees with counters");
    a_bus_off_entry: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        (I_EVENT.tx_error && !I_BUS_OFF_RECOVER && tec > 9'h0f7)
        |=> bus_off_flag ##1 (bus_off_flag || $past(I_BUS_OFF_RECOVER)))
        else $error("bus-off not entered above 255");
    a_lec_record: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        I_EVENT.code_valid |=> last_error_code == $past(I_EVENT.code))
        else $error("error code not recorded");
    a_rec_ceiling: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N) rec <= 8'h7f)
        else $error("receive counter above 127");
    a_rec_step: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        (I_EVENT.rx_error && I_EVENT.rx_error_large && !bus_off_flag &&
         !I_BUS_OFF_RECOVER && rec < 8'h70) |=> rec == $past(rec) + 8'h08)
        else $error("receive counter did not add 8");
    a_tec_step: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        (I_EVENT.tx_ok && !I_EVENT.tx_error && !bus_off_flag &&
         !I_BUS_OFF_RECOVER && tec != 9'h000) |=> tec == $past(tec) - 9'h001)
        else $error("transmit counter did not drop by 1");
    a_timing_locked: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        !I_INIT_MODE |=> $stable(timing))
        else $error("bit timing changed outside init mode");
    a_irq_follows: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        (irq_set[IRQ_WARN_POS] && irq_mask[IRQ_WARN_POS] &&
         $stable(irq_mask)) |=> ##1 O_IRQ)
        else $error("enabled warning rise gave no interrupt");
    a_quantum_len: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N || I_INIT_MODE)
        (tq_tick && timing.quantum_prescaler == 10'h002) |=>
        !tq_tick ##1 !tq_tick ##1 tq_tick)
        else $error("quantum length wrong");
endmodule
`default_nettype wire

// [cebt_pkg.sv]
// Constants, register layouts and types for the CAN error state and
// bit timing block.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
`default_nettype none
package cebt_pkg;
    localparam logic [7:0] ERROR_STATE_OFS = 8'h18;
    localparam logic [7:0] BIT_TIMING_OFS = 8'h1c;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
    localparam logic [31:0] ERROR_STATE_RST = 32'h00000000;
    localparam logic [31:0] BIT_TIMING_RST = 32'h01230000;
    localparam logic [3:0] IRQ_RST = 4'h0;
    // Bit positions of the error state register fields.
    localparam int WARN_POS = 0;
    localparam int PASSIVE_POS = 1;
    localparam int BUS_OFF_POS = 2;
    localparam int LEC_POS = 4;
    localparam int TEC_POS = 16;
    localparam int REC_POS = 24;
    // Bit positions of the interrupt status and mask registers.
    localparam int IRQ_WARN_POS = 0;
    localparam int IRQ_PASSIVE_POS = 1;
    localparam int IRQ_BUS_OFF_POS = 2;
    localparam int IRQ_LEC_POS = 3;
    // Fault confinement figures.
    localparam logic [9:0] WARN_LIMIT = 10'h060;
    localparam logic [9:0] PASSIVE_LIMIT = 10'h07f;
    localparam logic [9:0] BUS_OFF_LIMIT = 10'h0ff;
    localparam logic [8:0] REC_CEILING = 9'h07f;
    localparam logic [7:0] REC_RELOAD = 8'h78;
    localparam logic [9:0] SMALL_STEP = 10'h001;
    localparam logic [9:0] LARGE_STEP = 10'h008;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        LEC_NONE = 3'h0,
        LEC_STUFF = 3'h1,
        LEC_FORM = 3'h2,
        LEC_ACK = 3'h3,
        LEC_RECESSIVE = 3'h4,
        LEC_DOMINANT = 3'h5,
        LEC_CRC = 3'h6,
        LEC_SOFTWARE = 3'h7
    } cebt_lec_e;

    typedef enum logic [1:0] {
        PH_SYNC = 2'h0,
        PH_SEG1 = 2'h1,
        PH_SEG2 = 2'h2
    } cebt_phase_e;

    typedef struct packed {
        logic silent_enable;
        logic loopback_enable;
        logic [3:0] rsvd_hi;
        logic [1:0] resync_jump_width;
        logic rsvd_mid;
        logic [2:0] segment_two_length;
        logic [3:0] segment_one_length;
        logic [5:0] rsvd_lo;
        logic [9:0] quantum_prescaler;
    } cebt_timing_s;

    // Fault events reported by the protocol engine, one-cycle pulses.
    typedef struct packed {
        logic tx_error;
        logic tx_ok;
        logic rx_error;
        logic rx_error_large;
        logic rx_ok;
        logic code_valid;
        logic [2:0] code;
    } cebt_event_s;
endpackage
`default_nettype wire

// [cebt_node.sv]
// Model of the protocol engine and bus nodes that feed fault events.
// Assumes the bench calls send after a rising edge of the shared clock.
`default_nettype none
module cebt_node
    import cebt_pkg::*;
(
    input wire logic i_clk,
    output cebt_event_s o_event,
    output logic o_rx_edge
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_event = '0;
        o_rx_edge = 1'b0;
    end
    // Pulses go out back to back, as a busy bus would deliver them.
    task automatic send(input cebt_event_s e, input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_event <= e;
        end
        @(posedge i_clk);
        o_event <= '0;
    endtask
    // Holds the edge indication at a level for bit-stretching tests.
    task automatic hold_edge(input logic v);
        @(posedge i_clk);
        o_rx_edge <= v;
    endtask
endmodule
`default_nettype wire

// [can_error_state_and_bit_timing_tb.sv]
// Self-checking bench for the error state and bit timing block.
// Assumes cebt_pkg and cebt_core are compiled first.
`default_nettype none
module can_error_state_and_bit_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cebt_pkg::*;
    logic clk, rst_n, init, recover, awv, wv, bready, arv, rready;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, rdata;
    logic [1:0] bresp, rresp, rsp;
    logic awr, wr_r, bv, arr, rv, tq, smp, lb, sil, boff, pas, irq, rxe;
    cebt_event_s ev, ev_bus;
    int mismatches, cmp_count, n;
    cebt_core dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_INIT_MODE(init),
        .I_BUS_OFF_RECOVER(recover), .I_EVENT(ev_bus), .I_RX_EDGE(rxe),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .O_TQ_TICK(tq),
        .O_SAMPLE(smp), .O_LOOPBACK(lb), .O_SILENT(sil), .O_BUS_OFF(boff),
        .O_PASSIVE(pas), .O_IRQ(irq));
    cebt_node node (.i_clk(clk), .o_event(ev_bus), .o_rx_edge(rxe));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Readies depend only on registered state, so the falling edge is a
    // safe place to see whether the next rising edge takes the request.
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = ta || awr;
            tw = tw || wr_r;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!(ta && tw));
        do @(negedge clk); while (!bv);
        rsp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic read(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (!arr);
        @(posedge clk);
        arv <= 1'b0;
        do @(negedge clk); while (!rv);
        rd = rdata;
        rsp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        read(a);
        check(rd, exp);
    endtask
    // Counts clock periods from one pulse of the chosen output to the next.
    task automatic span(input bit s, output int c);
        c = 0;
        do @(negedge clk); while (!(s ? smp : tq));
        do begin
            @(negedge clk);
            c++;
        end while (!(s ? smp : tq));
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        {rst_n, recover, awv, wv, bready, arv, rready} = '0;
        init = 1'b1;
        {awa, ara, wd} = '0;
        mismatches = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rchk(ERROR_STATE_OFS, 32'h00000000);
        rchk(BIT_TIMING_OFS, 32'h01230000);
        write(BIT_TIMING_OFS, 32'hc1250002);
        rchk(BIT_TIMING_OFS, 32'hc1250002);
        check({sil, lb}, 32'h3);
        @(posedge clk);
        init <= 1'b0;
        span(0, n);
        check(n, 3);
        span(1, n);
        check(n, 30);
        // An edge early in every segment one stretches each bit by one
        // quantum; the first span only lets the timer settle.
        node.hold_edge(1'b1);
        span(1, n);
        span(1, n);
        check(n, 33);
        node.hold_edge(1'b0);
        write(BIT_TIMING_OFS, 32'h0);
        rchk(BIT_TIMING_OFS, 32'hc1250002);
        @(posedge clk);
        init <= 1'b1;
        write(BIT_TIMING_OFS, 32'h01230000);
        // The mode outputs follow the register one edge later.
        @(negedge clk);
        check({sil, lb}, 32'h0);
        write(IRQ_MASK_OFS, 32'h9);
        for (int c = 1; c < 7; c++) begin
            ev = '0;
            ev.code_valid = 1'b1;
            ev.code = c[2:0];
            node.send(ev, 1);
            rchk(ERROR_STATE_OFS, {25'h0, c[2:0], 4'h0});
        end
        rchk(IRQ_STATUS_OFS, 32'h8);
        check(irq, 32'h1);
        write(IRQ_STATUS_OFS, 32'h8);
        rchk(IRQ_STATUS_OFS, 32'h0);
        check(irq, 32'h0);
        write(ERROR_STATE_OFS, 32'h70);
        rchk(ERROR_STATE_OFS, 32'h70);
        ev = '0;
        ev.rx_error = 1'b1;
        ev.rx_error_large = 1'b1;
        node.send(ev, 15);
        rchk(ERROR_STATE_OFS, 32'h78000071);
        check(irq, 32'h1);
        ev.rx_error_large = 1'b0;
        node.send(ev, 7);
        rchk(ERROR_STATE_OFS, 32'h7f000073);
        check(pas, 32'h1);
        node.send(ev, 1);
        rchk(ERROR_STATE_OFS, 32'h78000071);
        ev = '0;
        ev.rx_ok = 1'b1;
        node.send(ev, 1);
        rchk(ERROR_STATE_OFS, 32'h77000071);
        ev = '0;
        ev.tx_error = 1'b1;
        node.send(ev, 31);
        rchk(ERROR_STATE_OFS, 32'h77f80073);
        node.send(ev, 1);
        rchk(ERROR_STATE_OFS, 32'h77f80077);
        check(boff, 32'h1);
        @(posedge clk);
        recover <= 1'b1;
        @(posedge clk);
        recover <= 1'b0;
        rchk(ERROR_STATE_OFS, 32'h70);
        rchk(IRQ_STATUS_OFS, 32'h7);
        write(IRQ_STATUS_OFS, 32'hf);
        rchk(IRQ_STATUS_OFS, 32'h0);
        check(irq, 32'h0);
        ev = '0;
        ev.tx_error = 1'b1;
        node.send(ev, 2);
        ev = '0;
        ev.tx_ok = 1'b1;
        node.send(ev, 1);
        rchk(ERROR_STATE_OFS, 32'h000f0070);
        write(8'h30, 32'h1);
        check(rsp, RESP_SLVERR);
        rchk(8'h30, 32'h0);
        check(rsp, RESP_SLVERR);
        results();
    end
endmodule
`default_nettype wire
